// [design/msc_ctrl.sv]
// conversion control: channel latch, successive approximation sequencer, output register
// Function
// - the channel code is captured on the latch strobe rising edge and held until the next one.
// - the latched code C,B,A as binary 0..7 selects the analog input of that index.
// - each conversion takes exactly eight compare-and-decide steps, one result bit per step.
// - a start rising edge clears the approximation register.
// - a start falling edge begins the conversion sequence.
// - a new start pulse abandons any conversion underway and restarts from it.
// - done falls between zero and eight clocks after the start rising edge.
// - result outputs are active high, one meaning a set bit.
// - codes step at half an LSB then every LSB to full scale, 256 codes.
// - the result register is loaded one clock before done rises.
// - data outputs are driven only while output enable is asserted.
`timescale 1ns/1ns
`include "msc_params.svh"
module msc_ctrl #(
  parameter int NUM_BITS = `MSC_NUM_BITS
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  wire logic              i_addr_latch,
  input  wire msc_pkg::msc_chan_t i_chan_sel,
  input  wire logic              i_conversion_start_input,
  input  wire logic              i_cmp_above,
  input  wire logic              i_out_enable,
  output logic [7:0]             o_analog_input_sel,
  output msc_pkg::msc_code_t     o_trial_code,
  output msc_pkg::msc_code_t     o_data_out,
  output msc_pkg::msc_code_t     o_data_oe_n,
  output logic                   o_done
);
  import msc_pkg::*;

  // pin synchronisers: three stages; for strobe, start and enable a change counts when stages two and three agree, the channel code is taken from stage three
  logic [2:0] latch_s_q;
  logic [2:0] start_s_q;
  logic [2:0] oe_s_q;
  logic [2:0] ch_s1_q, ch_s2_q, ch_s3_q;
  logic       latch_lvl_q, start_lvl_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      latch_s_q <= 3'h0;
      start_s_q <= 3'h0;
      oe_s_q    <= 3'h0;
      ch_s1_q   <= `MSC_CH_RST;
      ch_s2_q   <= `MSC_CH_RST;
      ch_s3_q   <= `MSC_CH_RST;
    end else begin
      latch_s_q <= {latch_s_q[1:0], i_addr_latch};
      start_s_q <= {start_s_q[1:0], i_conversion_start_input};
      oe_s_q    <= {oe_s_q[1:0], i_out_enable};
      ch_s1_q   <= i_chan_sel;
      ch_s2_q   <= ch_s1_q;
      ch_s3_q   <= ch_s2_q;
    end
  end

  // filtered levels change only when stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      latch_lvl_q <= 1'b0;
      start_lvl_q <= 1'b0;
    end else begin
      if (latch_s_q[1] == latch_s_q[2]) begin
        latch_lvl_q <= latch_s_q[2];
      end
      if (start_s_q[1] == start_s_q[2]) begin
        start_lvl_q <= start_s_q[2];
      end
    end
  end

  logic latch_rise, start_rise, start_fall;
  assign latch_rise = (latch_s_q[1] == latch_s_q[2]) && latch_s_q[2] && !latch_lvl_q;
  assign start_rise = (start_s_q[1] == start_s_q[2]) && start_s_q[2] && !start_lvl_q;
  assign start_fall = (start_s_q[1] == start_s_q[2]) && !start_s_q[2] && start_lvl_q;

  // channel latch and one-hot input select
  msc_chan_t chan_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      chan_q <= `MSC_CH_RST;
    end else if (latch_rise) begin
      chan_q <= ch_s3_q;
    end
  end

  logic [7:0] sel_d;
  genvar gi;
  generate
    for (gi = 0; gi < `MSC_NUM_CH; gi++) begin : g_sel
      assign sel_d[gi] = (chan_q == 3'(gi));
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_analog_input_sel <= `MSC_SEL_RST;
    end else begin
      o_analog_input_sel <= sel_d;
    end
  end

  // sequencer
  msc_state_t state_q;
  logic [2:0] step_q;
  msc_code_t  approximation_register_q;
  logic       done_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= MSC_IDLE;
      step_q  <= `MSC_STEP_RST;
    end else if (start_rise) begin
      state_q <= MSC_CLEAR;
    end else begin
      case (state_q)
        MSC_IDLE: begin
          state_q <= MSC_IDLE;
        end
        MSC_CLEAR: begin
          if (start_fall) begin
            state_q <= MSC_CONV;
            step_q  <= `MSC_MSB_IDX;
          end
        end
        MSC_CONV: begin
          if (step_q == 3'h0) begin
            state_q <= MSC_LOAD;
          end
          step_q <= step_q - 3'h1;
        end
        MSC_LOAD: begin
          state_q <= MSC_IDLE;
        end
        default: begin
          state_q <= MSC_IDLE;
        end
      endcase
    end
  end

  // trial code: current bit set on top of the decided bits
  msc_code_t trial_d;
  always_comb begin
    trial_d = approximation_register_q;
    if (state_q == MSC_CONV) begin
      trial_d[step_q] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      approximation_register_q <= `MSC_TRIAL_RST;
    end else if (start_rise) begin
      approximation_register_q <= `MSC_TRIAL_RST;
    end else if (state_q == MSC_CONV) begin
      approximation_register_q[step_q] <= i_cmp_above;
    end
  end

  // comparator decides on the trial level; code ladder realises the half-LSB offset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_trial_code <= `MSC_TRIAL_RST;
    end else begin
      o_trial_code <= trial_d;
    end
  end

  // data register loads with the last decision, so it leads done by one clock;
  // a start edge on that same clock abandons the result instead of loading it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_data_out <= `MSC_RESULT_RST;
    end else if (!start_rise && state_q == MSC_CONV && step_q == 3'h0) begin
      o_data_out <= approximation_register_q | {7'h00, i_cmp_above};
    end
  end

  // done low on the start edge itself, high the cycle after the result loads
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_q <= 1'b1;
    end else if (start_rise) begin
      done_q <= 1'b0;
    end else if (state_q == MSC_LOAD) begin
      done_q <= 1'b1;
    end
  end
  assign o_done = done_q;

  // outputs driven only while enabled; enable low means driving
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_data_oe_n <= `MSC_OE_N_RST;
    end else if (oe_s_q[1] == oe_s_q[2]) begin
      o_data_oe_n <= oe_s_q[2] ? 8'h00 : 8'hff;
    end
  end

  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  done_falls_fast_a: assert property (start_rise |=> !o_done)
    else $error("done did not fall after start rise");
  clear_on_start_a: assert property (start_rise |=> approximation_register_q == 8'h00)
    else $error("approximation register not cleared");
  // a restart inside the eight steps leaves this one vacuous
  eight_steps_a: assert property (
    (state_q == MSC_CLEAR && start_fall && !start_rise) ##1 (!start_rise)[*8] |=>
      (state_q == MSC_LOAD && $past(state_q, 8) == MSC_CONV))
    else $error("conversion not eight steps");
  load_before_done_a: assert property (
    $rose(o_done) |-> $stable(o_data_out) && $past(state_q) == MSC_LOAD)
    else $error("done rose without load");
  done_holds_a: assert property (o_done && !start_rise |=> o_done)
    else $error("done dropped without start");
  result_stable_a: assert property (o_done |=> $stable(o_data_out))
    else $error("result changed while done");
  restart_a: assert property (start_rise |=> state_q == MSC_CLEAR)
    else $error("start did not restart");
  chan_latch_a: assert property (!latch_rise |=> $stable(chan_q))
    else $error("channel changed without strobe");
  sel_onehot_a: assert property (##1 $onehot(o_analog_input_sel))
    else $error("select not one hot");

  cov_conv_c: cover property (state_q == MSC_LOAD ##1 o_done);
  cov_abort_c: cover property (state_q == MSC_CONV ##1 start_rise);
  cov_chan_c: cover property (latch_rise ##1 chan_q == 3'h7);
endmodule

// [design/msc_params.svh]
// constants for the multiplexed conversion control block
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_NUM_BITS      8
`define MSC_NUM_CH        8
`define MSC_CH_W          3
`define MSC_RESULT_RST    8'h00
`define MSC_TRIAL_RST     8'h00
`define MSC_CH_RST        3'h0
`define MSC_STEP_RST      3'h0
`define MSC_MSB_IDX       3'h7
`define MSC_SEL_RST       8'h01
`define MSC_OE_N_RST      8'hff
`endif

// [design/msc_pkg.sv]
// types for the multiplexed conversion control block
`include "msc_params.svh"
package msc_pkg;
  typedef logic [`MSC_NUM_BITS-1:0] msc_code_t;
  typedef logic [`MSC_CH_W-1:0]     msc_chan_t;
  typedef enum logic [1:0] {
    MSC_IDLE  = 2'b00,
    MSC_CLEAR = 2'b01,
    MSC_CONV  = 2'b11,
    MSC_LOAD  = 2'b10
  } msc_state_t;
endpackage

// [tb/msc_analog_model.sv]
// analog side model: eight channel levels and an ideal comparator
`timescale 1ns/1ns
module msc_analog_model (
  input  wire logic [63:0] i_levels,
  input  wire logic [7:0]  i_sel,
  input  wire logic [7:0]  i_trial,
  output logic             o_above
);
  logic [7:0] vin, lb, nxt;
  // the trial on the port lags a cycle, so the live trial is rebuilt from it
  always_comb begin
    vin = 8'h00;
    for (int n = 0; n < 8; n++)
      if (i_sel[n]) vin = i_levels[n*8 +: 8];
    lb  = i_trial & (~i_trial + 8'h01);
    nxt = (i_trial == 8'h00) ? 8'h80 : (((vin >= i_trial) ? i_trial : i_trial & ~lb) | (lb >> 1));
    o_above = vin >= nxt;
  end
endmodule

// [tb/tb.sv]
// random and corner conversions against the conversion control block
`timescale 1ns/1ns
module tb;
  import msc_pkg::*;
  logic        clk = 0, rst = 1, strobe = 0, start = 0, oe = 0, above, done;
  msc_chan_t   ch = 3'h0;
  logic [7:0]  sel, v, c, dout_prev;
  msc_code_t   trial, dout, oe_n;
  logic [63:0] lv = 64'h0;
  int          errors = 0, checks_done = 0, rises;
  msc_ctrl msc_ctrl_i (.i_ref_clk(clk), .i_reset(rst), .i_addr_latch(strobe), .i_chan_sel(ch),
    .i_conversion_start_input(start), .i_cmp_above(above), .i_out_enable(oe),
    .o_analog_input_sel(sel), .o_trial_code(trial), .o_data_out(dout), .o_data_oe_n(oe_n),
    .o_done(done));
  msc_analog_model msc_analog_model_i (.i_levels(lv), .i_sel(sel), .i_trial(trial),
    .o_above(above));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // keeps the data seen one cycle earlier, so the lead of data over done can be checked
  task automatic tick(input int n);
    repeat (n) begin
      dout_prev = dout;
      @(negedge clk);
    end
  endtask
  // bounded wait on the done level; running out ends the run
  task automatic wait_done(input logic lvl, input int lim);
    for (int n = 0; done !== lvl; n++) begin
      if (n == lim) begin
        errors++;
        report_and_stop();
      end
      tick(1);
    end
  endtask
  // start held well past the three-flop sync so the rise is surely seen
  task automatic launch;
    start = 1;
    wait_done(1'b0, 12);
    tick(6);
    chk(trial, 8'h00);
    start = 0;
  endtask
  initial begin
    void'($urandom(92459));
    tick(16);
    rst = 0;
    tick(4);
    chk(oe_n, 8'hff);
    oe = 1;
    tick(5);
    chk(oe_n, 8'h00);
    for (int i = 0; i < 20; i++) begin
      c = (i < 8) ? i[7:0] : 8'($urandom % 8);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      chk({7'h00, done}, 8'h01);
      ch = c[2:0];
      strobe = 1;
      tick(4);
      strobe = 0;
      // pins move after the strobe; the selection must not follow them
      ch = ~c[2:0];
      lv[c*8 +: 8] = v;
      tick(4);
      chk(sel, 8'h01 << c);
      launch();
      if (i % 4 == 3) begin
        tick(4);
        chk({7'h00, done}, 8'h00);
        v = ~v;
        lv[c*8 +: 8] = v;
        launch();
      end
      wait_done(1'b1, 40);
      chk(dout_prev, v);
      chk(dout, v);
      lv[c*8 +: 8] = ~v;
      tick(6);
      chk(dout, v);
    end
    // done looped back to start after the external pulses above
    rises = 0;
    for (int n = 0; n < 120; n++) begin
      if (done && !start)
        rises++;
      start = done;
      tick(1);
    end
    start = 0;
    chk(8'(rises > 2), 8'h01);
    oe = 0;
    tick(5);
    chk(oe_n, 8'hff);
    report_and_stop();
  end
endmodule
